/* include/ext_bus_defines.svh */
`ifndef EXT_BUS_DEFINES_SVH
`define EXT_BUS_DEFINES_SVH

// ****************************************************************
// cycle counts, one count = one clock period
// ****************************************************************
`define ALE_CYC 4'h2
`define FETCH_SETUP_CYC 4'h1
`define DATA_SETUP_CYC 4'h3
`define PROG_STROBE_CYC 4'h3
`define RDWR_CYC 4'h6
`define FETCH_TAIL_CYC 4'h1
`define READ_TAIL_CYC 4'h2
`define WRITE_TAIL_CYC 4'h1

// ****************************************************************
// machine phases, twelve per machine cycle, state1_phase1 is zero
// ****************************************************************
`define PHASE_LAST 4'hB
`define PHASE_PORT_SAMPLE 4'h9
`define PHASE_PORT_UPDATE 4'hB

// ****************************************************************
// widths
// ****************************************************************
`define CNT_W 4
`define PHASE_W 4
`define ADDR_W 16
`define DATA_W 8

`endif

/* include/ext_bus_pkg.sv */
`include "ext_bus_defines.svh"

package ext_bus_pkg;

  typedef enum logic [1:0] {
    KIND_FETCH = 2'h0,
    KIND_READ = 2'h1,
    KIND_WRITE = 2'h2
  } kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_SETUP = 3'h3,
    ST_STROBE = 3'h2,
    ST_TAIL = 3'h6
  } bus_state_t;

  typedef struct packed {
    kind_t kind;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
  } req_t;

  typedef struct packed {
    logic valid;
    logic [`DATA_W-1:0] data;
  } resp_t;

  typedef struct packed {
    bus_state_t st;
    logic [`CNT_W-1:0] cnt;
    req_t req;
    resp_t resp;
    logic ale;
    logic prog_store_strobe_n;
    logic rd_n;
    logic wr_n;
    logic [`DATA_W-1:0] low_addr_data_port_o;
    logic low_addr_data_port_oe;
    logic [`PHASE_W-1:0] phase;
    logic [`DATA_W-1:0] port_in;
    logic [`DATA_W-1:0] port_out;
    logic [`DATA_W-1:0] port_pend;
    logic prog_mode;
  } state_t;

endpackage

/* rtl/ext_bus.sv */
`timescale 1ns/1ns
`include "ext_bus_defines.svh"

module ext_bus (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input ext_bus_pkg::req_t req,
  output logic req_ready,
  output ext_bus_pkg::resp_t resp,
  output logic ale_o,
  output logic ale_oe,
  input wire logic ale_i,
  output logic prog_store_strobe_n_o,
  output logic prog_store_strobe_oe,
  input wire logic prog_store_strobe_i,
  output logic rd_n,
  output logic wr_n,
  output logic [`DATA_W-1:0] low_addr_data_port_o,
  output logic low_addr_data_port_oe,
  input wire logic [`DATA_W-1:0] low_addr_data_port_i,
  output logic [`DATA_W-1:0] high_addr_port,
  input wire logic reset_pin,
  input wire logic [`DATA_W-1:0] gpio_in,
  output logic [`DATA_W-1:0] gpio_out,
  output logic [`DATA_W-1:0] gpio_in_sampled,
  input wire logic [`DATA_W-1:0] gpio_out_wdata,
  input wire logic rom_rd_req,
  output logic rom_rd_en,
  output logic prog_mode
);

  ext_bus_pkg::state_t q, d;
  logic [`DATA_W+2:0] pins_sync;

  // ****************************************************************
  // per-kind cycle decode
  // ****************************************************************
  function automatic logic [`CNT_W-1:0] setup_len(input ext_bus_pkg::kind_t k);
    setup_len = (k == ext_bus_pkg::KIND_FETCH) ? `FETCH_SETUP_CYC : `DATA_SETUP_CYC;
  endfunction

  function automatic logic [`CNT_W-1:0] strobe_len(input ext_bus_pkg::kind_t k);
    strobe_len = (k == ext_bus_pkg::KIND_FETCH) ? `PROG_STROBE_CYC : `RDWR_CYC;
  endfunction

  function automatic logic [`CNT_W-1:0] tail_len(input ext_bus_pkg::kind_t k);
    case (k)
      ext_bus_pkg::KIND_FETCH: tail_len = `FETCH_TAIL_CYC;
      ext_bus_pkg::KIND_READ: tail_len = `READ_TAIL_CYC;
      default: tail_len = `WRITE_TAIL_CYC;
    endcase
  endfunction

  sync2 #(.W(`DATA_W + 3)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({reset_pin, ale_i, prog_store_strobe_i, gpio_in}),
    .q(pins_sync)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    d = q;
    d.resp.valid = 1'b0;
    d.phase = (q.phase == `PHASE_LAST) ? '0 : q.phase + 4'h1;
    // pins released by the device so the programmer can drive them
    d.prog_mode = pins_sync[`DATA_W+2] & ~pins_sync[`DATA_W+1] & pins_sync[`DATA_W];
    if (q.phase == `PHASE_PORT_SAMPLE)
    begin
      d.port_in = pins_sync[`DATA_W-1:0];
    end
    if (q.phase == `PHASE_PORT_UPDATE)
    begin
      d.port_out = q.port_pend;
    end
    d.port_pend = gpio_out_wdata;
    // counting states step down; every change into a counting state reloads the count, the return to idle does not
    d.cnt = q.cnt - 4'h1;
    case (q.st)
      ext_bus_pkg::ST_IDLE:
      begin
        // a new address phase starts only from idle
        if (req_valid && !q.prog_mode)
        begin
          d.req = req;
          d.st = ext_bus_pkg::ST_ADDR;
          d.cnt = `ALE_CYC - 4'h1;
          d.ale = 1'b1;
          d.low_addr_data_port_o = req.addr[7:0];
          d.low_addr_data_port_oe = 1'b1;
        end
      end
      ext_bus_pkg::ST_ADDR:
      begin
        if (q.cnt == '0)
        begin
          d.ale = 1'b0;
          d.st = ext_bus_pkg::ST_SETUP;
          d.cnt = setup_len(q.req.kind) - 4'h1;
        end
      end
      ext_bus_pkg::ST_SETUP:
      begin
        // first setup cycle still shows the low address
        if (q.req.kind == ext_bus_pkg::KIND_WRITE)
        begin
          d.low_addr_data_port_o = q.req.wdata;
        end
        else
        begin
          d.low_addr_data_port_oe = 1'b0;
        end
        if (q.cnt == '0)
        begin
          d.st = ext_bus_pkg::ST_STROBE;
          d.cnt = strobe_len(q.req.kind) - 4'h1;
          d.prog_store_strobe_n = (q.req.kind != ext_bus_pkg::KIND_FETCH);
          d.rd_n = (q.req.kind != ext_bus_pkg::KIND_READ);
          d.wr_n = (q.req.kind != ext_bus_pkg::KIND_WRITE);
        end
      end
      ext_bus_pkg::ST_STROBE:
      begin
        if (q.cnt == '0)
        begin
          d.prog_store_strobe_n = 1'b1;
          d.rd_n = 1'b1;
          d.wr_n = 1'b1;
          if (q.req.kind != ext_bus_pkg::KIND_WRITE)
          begin
            // taken on the edge that ends the strobe
            d.resp.valid = 1'b1;
            d.resp.data = low_addr_data_port_i;
          end
          d.st = ext_bus_pkg::ST_TAIL;
          d.cnt = tail_len(q.req.kind) - 4'h1;
        end
      end
      ext_bus_pkg::ST_TAIL:
      begin
        // write data stays driven through the tail
        // idle tail gives memory time to release the bus
        if (q.cnt == '0)
        begin
          d.low_addr_data_port_oe = 1'b0;
          d.st = ext_bus_pkg::ST_IDLE;
        end
      end
      default:
      begin
        d.st = ext_bus_pkg::ST_IDLE;
      end
    endcase
    if (q.prog_mode)
    begin
      d.st = ext_bus_pkg::ST_IDLE;
      d.ale = 1'b0;
      d.prog_store_strobe_n = 1'b1;
      d.rd_n = 1'b1;
      d.wr_n = 1'b1;
      d.low_addr_data_port_oe = 1'b0;
    end
  end

  // no clock-derived timers: a stopped clock just freezes this state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.st <= ext_bus_pkg::ST_IDLE;
      q.req.kind <= ext_bus_pkg::KIND_FETCH;
      q.prog_store_strobe_n <= 1'b1;
      q.rd_n <= 1'b1;
      q.wr_n <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign req_ready = (q.st == ext_bus_pkg::ST_IDLE) && !q.prog_mode;
  assign resp = q.resp;
  assign ale_o = q.ale;
  assign ale_oe = ~q.prog_mode;
  assign prog_store_strobe_n_o = q.prog_store_strobe_n;
  assign prog_store_strobe_oe = ~q.prog_mode;
  assign rd_n = q.rd_n;
  assign wr_n = q.wr_n;
  assign low_addr_data_port_o = q.low_addr_data_port_o;
  assign low_addr_data_port_oe = q.low_addr_data_port_oe;
  assign high_addr_port = q.req.addr[15:8];
  assign gpio_out = q.port_out;
  assign gpio_in_sampled = q.port_in;
  assign rom_rd_en = rom_rd_req & q.prog_mode;
  assign prog_mode = q.prog_mode;

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_ale_high2;
    q.ale [*2] ##1 !q.ale;
  endsequence

  sequence s_rdwr_low6(logic s);
    !s [*6] ##1 s;
  endsequence

  AST_ADDR_BEFORE_ALE: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(q.ale) |-> $past(q.low_addr_data_port_oe, 2) && $stable(q.low_addr_data_port_o))
    else $error("address not valid before latch strobe fell");

  AST_ADDR_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(q.ale) |-> q.low_addr_data_port_oe && q.low_addr_data_port_o == q.req.addr[7:0])
    else $error("low address not held after latch strobe fell");

  AST_ADDR_STABLE: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st != ext_bus_pkg::ST_IDLE && $past(q.st) != ext_bus_pkg::ST_IDLE) |-> $stable(q.req.addr))
    else $error("address changed inside a cycle");

  AST_ALE_WIDTH: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(q.ale) |-> s_ale_high2)
    else $error("latch strobe width wrong");

  AST_PROG_STROBE_TIMING: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(q.ale) && q.req.kind == ext_bus_pkg::KIND_FETCH) |->
      q.prog_store_strobe_n ##1 !q.prog_store_strobe_n [*3] ##1 q.prog_store_strobe_n)
    else $error("program strobe timing wrong");

  AST_FETCH_CAPTURE: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(q.prog_store_strobe_n) |-> q.resp.valid)
    else $error("fetch data not captured at strobe end");

  AST_RD_TIMING: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(q.ale) && q.req.kind == ext_bus_pkg::KIND_READ) |->
      q.rd_n [*3] ##1 s_rdwr_low6(q.rd_n))
    else $error("read strobe timing wrong");

  AST_WR_TIMING: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(q.ale) && q.req.kind == ext_bus_pkg::KIND_WRITE) |->
      q.wr_n [*3] ##1 s_rdwr_low6(q.wr_n))
    else $error("write strobe timing wrong");

  AST_WR_DATA_SETUP: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(q.wr_n) |-> $past(q.low_addr_data_port_o) == q.req.wdata && q.low_addr_data_port_oe)
    else $error("write data not set up before strobe");

  AST_WR_DATA_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(q.wr_n) |-> q.low_addr_data_port_oe && q.low_addr_data_port_o == q.req.wdata)
    else $error("write data not held after strobe");

  AST_PORT_SAMPLE: assert property (@(posedge clk) disable iff (!rst_n)
    $past(q.phase) == `PHASE_PORT_SAMPLE |-> q.port_in == $past(pins_sync[`DATA_W-1:0]))
    else $error("port input not sampled in its phase");

  AST_PORT_UPDATE: assert property (@(posedge clk) disable iff (!rst_n)
    $past(q.phase) != `PHASE_PORT_UPDATE |-> $stable(q.port_out))
    else $error("port output changed outside its phase");

  AST_ROM_READ: assert property (@(posedge clk) disable iff (!rst_n)
    rom_rd_en |-> $past(pins_sync[`DATA_W+2:`DATA_W]) == 3'h5)
    else $error("array read outside programming mode");

  AST_ONE_TXN: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(q.ale) |-> $past(q.st) == ext_bus_pkg::ST_IDLE && q.rd_n && q.wr_n)
    else $error("address phase started inside a transaction");

endmodule // ext_bus

/* rtl/sync2.sv */
`timescale 1ns/1ns

// ****************************************************************
// two-stage synchroniser
// ****************************************************************
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule // sync2

/* sim/ext_mem_model.sv */
`timescale 1ns/1ns

// ****
// external memory with address latch
// ****
module ext_mem_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic ale,
  input wire logic prog_store_strobe_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] dut_d,
  input wire logic dut_oe,
  output logic [7:0] bus
);
  logic [7:0] mem [0:255];
  logic [7:0] addr_q;
  logic [7:0] wbuf_q;
  logic [7:0] last_q = 8'h00;
  logic ale_q = 1'b0;
  logic wr_q = 1'b1;
  logic drive;
  logic [3:0] low_cnt = 4'h0;

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(255 - i);
  end

  // a slow part waits one period, still well inside the access window
  assign drive = (!prog_store_strobe_n || !rd_n) && (!slow || low_cnt != 4'h0);
  // released bus shows a toggling pattern, never the last value
  assign bus = dut_oe ? dut_d : (drive ? mem[addr_q] : ~last_q);

  always @(posedge clk)
  begin
    ale_q <= ale;
    wr_q <= wr_n;
    last_q <= bus;
    low_cnt <= (!prog_store_strobe_n || !rd_n) ? low_cnt + 4'h1 : 4'h0;
    if (ale_q && !ale)
      addr_q <= bus;
    if (!wr_n)
      wbuf_q <= bus;
    if (!wr_q && wr_n)
      mem[addr_q] <= wbuf_q;
  end
endmodule // ext_mem_model

/* sim/external_memory_bus_timing_tb.sv */
`timescale 1ns/1ns
`include "ext_bus_defines.svh"

module external_memory_bus_timing_tb;
  logic clk = 1'b0;
  logic run = 1'b1;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  ext_bus_pkg::req_t req = '0;
  logic req_ready;
  ext_bus_pkg::resp_t resp;
  logic ale_o, ale_oe, ale_i, ps_o, ps_oe, ps_i, rd_n, wr_n, bus_oe, prog_mode, rom_rd_en;
  logic [`DATA_W-1:0] bus_o, bus_i, high_addr_port, gpio_out, gpio_in_sampled;
  logic [`DATA_W-1:0] gpio_in = 8'h00;
  logic [`DATA_W-1:0] gpio_out_wdata = 8'h00;
  logic reset_pin = 1'b0;
  logic rom_rd_req = 1'b0;
  logic slow = 1'b0;
  logic pin_ale = 1'b1;
  logic pin_ps = 1'b1;
  int n_fail = 0;
  int checked = 0;

  always #25 clk = run ? ~clk : clk;

  // pins read back from whoever drives them
  assign ale_i = ale_oe ? ale_o : pin_ale;
  assign ps_i = ps_oe ? ps_o : pin_ps;

  ext_bus dut_u (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .resp(resp), .ale_o(ale_o), .ale_oe(ale_oe), .ale_i(ale_i),
    .prog_store_strobe_n_o(ps_o), .prog_store_strobe_oe(ps_oe), .prog_store_strobe_i(ps_i),
    .rd_n(rd_n), .wr_n(wr_n), .low_addr_data_port_o(bus_o), .low_addr_data_port_oe(bus_oe),
    .low_addr_data_port_i(bus_i), .high_addr_port(high_addr_port), .reset_pin(reset_pin),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_in_sampled(gpio_in_sampled),
    .gpio_out_wdata(gpio_out_wdata), .rom_rd_req(rom_rd_req), .rom_rd_en(rom_rd_en),
    .prog_mode(prog_mode));

  ext_mem_model mem_u (.clk(clk), .slow(slow), .ale(ale_o), .prog_store_strobe_n(ps_o),
    .rd_n(rd_n), .wr_n(wr_n), .dut_d(bus_o), .dut_oe(bus_oe), .bus(bus_i));

  // ****
  // checking and closing
  // ****
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %0h seen %0h", s, e, g);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // one bus transaction, the strobes, address, bus data and response compared cycle by cycle
  task automatic xfer(input ext_bus_pkg::kind_t k, input logic [15:0] a,
    input logic [7:0] wd, input logic [7:0] ed, input logic stall);
    logic f;
    logic r;
    logic w;
    f = (k == ext_bus_pkg::KIND_FETCH);
    r = (k == ext_bus_pkg::KIND_READ);
    w = (k == ext_bus_pkg::KIND_WRITE);
    chk("ready", 16'h1, 16'(req_ready));
    req = '{kind: k, addr: a, wdata: wd};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    for (int c = 0; c < 14; c++)
    begin
      chk("ale", 16'(c < 2), 16'(ale_o));
      chk("prog_strobe", 16'(!(f && c >= 3 && c <= 5)), 16'(ps_o));
      chk("rd", 16'(!(r && c >= 5 && c <= 10)), 16'(rd_n));
      chk("wr", 16'(!(w && c >= 5 && c <= 10)), 16'(wr_n));
      chk("resp_valid", 16'((f && c == 6) || (r && c == 11)), 16'(resp.valid));
      if (c < 3)
      begin
        chk("addr_oe", 16'h1, 16'(bus_oe));
        chk("addr_lo", 16'(a[7:0]), 16'(bus_o));
      end
      if (w && c >= 3 && c <= 11)
      begin
        chk("wdata_oe", 16'h1, 16'(bus_oe));
        chk("wdata", 16'(wd), 16'(bus_o));
      end
      chk("addr_hi", 16'(a[15:8]), 16'(high_addr_port));
      if ((f && c == 6) || (r && c == 11))
        chk("rdata", 16'(ed), 16'(resp.data));
      if (stall && c == 4)
      begin
        // clock parked low, then parked high, in the middle of the strobe
        run = 1'b0;
        #2000;
        run = 1'b1;
        @(posedge clk);
        run = 1'b0;
        #2000;
        run = 1'b1;
      end
      @(negedge clk);
    end
  endtask

  task automatic ports;
    int t_in;
    int t_out;
    t_in = -1;
    t_out = -1;
    gpio_in = 8'h3C;
    gpio_out_wdata = 8'hC3;
    for (int c = 0; c < 16; c++)
    begin
      @(negedge clk);
      if (t_in < 0 && gpio_in_sampled === 8'h3C)
        t_in = c;
      if (t_out < 0 && gpio_out === 8'hC3)
        t_out = c;
    end
    chk("port_in", 16'h3C, 16'(gpio_in_sampled));
    chk("port_out", 16'hC3, 16'(gpio_out));
    chk("port_gap", 16'h2, 16'((t_out - t_in + 24) % 12));
  endtask

  task automatic prog;
    int bad;
    bad = 0;
    rom_rd_req = 1'b1;
    @(negedge clk);
    chk("rom_rd_normal", 16'h0, 16'(rom_rd_en));
    reset_pin = 1'b1;
    pin_ale = 1'b0;
    repeat (5) @(negedge clk);
    chk("prog_mode", 16'h1, 16'(prog_mode));
    chk("ready_prog", 16'h0, 16'(req_ready));
    chk("pins_released", 16'h0, 16'({ale_oe, ps_oe}));
    chk("rom_rd_prog", 16'h1, 16'(rom_rd_en));
    // one programming pulse of 300 us at 50 ns a clock; the mode must hold throughout
    for (int c = 0; c < 6000; c++)
    begin
      @(negedge clk);
      if (prog_mode !== 1'b1 || req_ready !== 1'b0 || rom_rd_en !== 1'b1)
        bad++;
    end
    chk("prog_pulse_hold", 16'h0, 16'(bad));
    reset_pin = 1'b0;
    pin_ale = 1'b1;
    repeat (5) @(negedge clk);
    chk("prog_exit", 16'h0, 16'({prog_mode, rom_rd_en}));
  endtask

  // ****
  // main sequence
  // ****
  initial
  begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    chk("idle_strobes", 16'h7, 16'({ps_o, rd_n, wr_n}));
    chk("idle_ale_oe", 16'h0, 16'({ale_o, bus_oe}));
    xfer(ext_bus_pkg::KIND_FETCH, 16'h1234, 8'h00, 8'hCB, 1'b0);
    slow = 1'b1;
    xfer(ext_bus_pkg::KIND_FETCH, 16'hAB80, 8'h00, 8'h7F, 1'b1);
    xfer(ext_bus_pkg::KIND_WRITE, 16'h0510, 8'hA5, 8'h00, 1'b0);
    xfer(ext_bus_pkg::KIND_READ, 16'h0510, 8'h00, 8'hA5, 1'b0);
    slow = 1'b0;
    xfer(ext_bus_pkg::KIND_READ, 16'hFFFF, 8'h00, 8'h00, 1'b0);
    ports();
    prog();
    results();
  end

  initial
  begin
    #400000;
    n_fail++;
    results();
  end
endmodule // external_memory_bus_timing_tb
